// ===== src/nfhc_pkg.sv
// Purpose: shared constants and types for the flash host controller
// Assumes: 10 MHz system clock, eight-bit flash with 528-byte pages
// Notes: wait counts derive from a time and the clock period; read strobe phases and address cycle counts are fixed
package nfhc_pkg;
  // =========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WB_WAIT_NS = 200;
  localparam int WB_WAIT_CYC = (WB_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_BUSY_US = 15;
  localparam int READ_BUSY_CYC = (READ_BUSY_US * 1000) / CLK_PERIOD_NS;
  localparam int RD_CYCLE_NS = 50;
  localparam int RD_CYCLE_CYC = (RD_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RD_LOW_LAST = 2'h2;
  localparam logic [1:0] RD_SAMPLE = 2'h3;
  // =========================================================
  // page geometry and address cycles
  localparam logic [9:0] PAGE_BYTES = 10'h210;
  localparam logic [1:0] ADDR_CYC_PAGE = 2'h3;
  localparam logic [1:0] ADDR_CYC_ERASE = 2'h2;
  // =========================================================
  // command codes
  localparam logic [7:0] CMD_READ_LO = 8'h00;
  localparam logic [7:0] CMD_READ_HI = 8'h01;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  // =========================================================
  // types
  typedef enum logic [1:0] {NFHC_OP_READ, NFHC_OP_PROG, NFHC_OP_ERASE} nfhc_op_type;
  typedef struct packed {
    nfhc_op_type op;
    logic [8:0] col;
    logic [15:0] row;
  } nfhc_req_type;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic rd_n;
    logic wp_n;
  } nfhc_pins_type;
endpackage

// ===== src/nfhc_ctrl.sv
// Purpose: host controller driving an eight-bit flash through its strobes
// Assumes: one request at a time; external pull-up on the ready/busy line
// Notes: each write strobe is one cycle low, at least one high; read strobe three low, one high
//
// Behaviour
// - shared bus carries command, address, write data in and read data out.
// - command latch high: bus byte taken as command on write strobe rise.
// - address latch high: bus byte taken as address on write strobe rise.
// - ready/busy is open drain; an external pull-up supplies the high level.
// - page data read one byte per read strobe, cycle at least 50 ns.
// - page read and program give column, low row, high row addresses.
// - block erase gives only the two row address cycles.
// - program and erase use a setup command then an execute command.
`timescale 1ns/1ps
module nfhc_ctrl
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // request port
  input wire logic REQ_VALID,
  input wire nfhc_pkg::nfhc_req_type REQ,
  output logic REQ_READY,
  input wire logic ALLOW_WRITE,
  // write data stream
  input wire logic [7:0] WDATA,
  input wire logic WDATA_VALID,
  output logic WDATA_READY,
  // read data stream and status
  output logic [7:0] RDATA,
  output logic RDATA_VALID,
  output logic DONE,
  output logic READ_LATE,
  // flash pins
  output nfhc_pkg::nfhc_pins_type PINS,
  input wire logic [7:0] SHARED_IO_BUS_IN,
  output logic [7:0] SHARED_IO_BUS_OUT,
  output logic SHARED_IO_BUS_OE,
  input wire logic READY_BUSY_IN
);
  // =========================================================
  // state and registers
  typedef enum logic [2:0] {S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WAIT, S_RDATA, S_DONE} nfhc_state_type;
  nfhc_state_type state, next_state;
  nfhc_pkg::nfhc_req_type req, next_req;
  nfhc_pkg::nfhc_pins_type pins, next_pins;
  logic [1:0] ph, next_ph;
  logic [1:0] aidx, next_aidx;
  logic [9:0] cnt, next_cnt;
  logic [7:0] dbus, next_dbus;
  logic oe, next_oe;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic done, next_done;
  logic late, next_late;
  logic [7:0] io_s1, io_s2;
  logic rb_s1, rb_s2;
  logic [1:0] acyc;
  logic alast, dlast, load_w;
  logic [9:0] rd_last;

  // picks the byte for an address cycle; erase skips the column
  function automatic logic [7:0] addr_byte(input nfhc_pkg::nfhc_req_type r, input logic [1:0] i);
    logic [1:0] k;
    k = (r.op == nfhc_pkg::NFHC_OP_ERASE) ? 2'(i + 2'h1) : i;
    case (k)
      2'h0: addr_byte = r.col[7:0];
      2'h1: addr_byte = r.row[7:0];
      default: addr_byte = r.row[15:8];
    endcase
  endfunction

  // =========================================================
  // pin input synchronisers
  always_ff @(posedge CLK_SYS)
  begin
    io_s1 <= SHARED_IO_BUS_IN;
    io_s2 <= io_s1;
    rb_s1 <= READY_BUSY_IN;
    rb_s2 <= rb_s1;
  end

  // sequence helpers
  assign acyc = (req.op == nfhc_pkg::NFHC_OP_ERASE) ? nfhc_pkg::ADDR_CYC_ERASE : nfhc_pkg::ADDR_CYC_PAGE;
  assign alast = (aidx == 2'(acyc - 2'h1));
  assign dlast = (cnt == 10'(nfhc_pkg::PAGE_BYTES - 10'h001));
  assign rd_last = 10'(nfhc_pkg::PAGE_BYTES - 10'h001 - {1'b0, req.col});
  assign load_w = (ph == 2'h1) && (((state == S_ADDR) && alast && (req.op == nfhc_pkg::NFHC_OP_PROG))
                  || ((state == S_WDATA) && !dlast));
  // ready only while idle and the device reports ready, so an offered request is never dropped
  assign REQ_READY = (state == S_IDLE) && rb_s2;
  assign WDATA_READY = load_w;

  // =========================================================
  // next-state logic
  always_comb
  begin
    next_state = state;
    next_req = req;
    next_pins = pins;
    next_ph = ph;
    next_aidx = aidx;
    next_cnt = cnt;
    next_dbus = dbus;
    next_oe = oe;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_done = 1'b0;
    next_late = late;
    next_pins.wp_n = ALLOW_WRITE;
    case (state)
      S_IDLE:
      begin
        next_pins = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, rd_n: 1'b1, wp_n: ALLOW_WRITE};
        next_oe = 1'b0;
        // new array command only while the device is ready
        if (REQ_VALID && rb_s2)
        begin
          next_req = REQ;
          next_late = 1'b0;
          next_state = S_CMD1;
          next_pins.ce_n = 1'b0;
          next_pins.cle = 1'b1;
          next_pins.we_n = 1'b0;
          next_oe = 1'b1;
          next_ph = 2'h0;
          next_aidx = 2'h0;
          case (REQ.op)
            nfhc_pkg::NFHC_OP_PROG: next_dbus = nfhc_pkg::CMD_PROG_SETUP;
            nfhc_pkg::NFHC_OP_ERASE: next_dbus = nfhc_pkg::CMD_ERASE_SETUP;
            default: next_dbus = REQ.col[8] ? nfhc_pkg::CMD_READ_HI : nfhc_pkg::CMD_READ_LO;
          endcase
        end
      end
      S_CMD1, S_ADDR, S_WDATA, S_CMD2:
      begin
        if (ph == 2'h0)
        begin
          // write strobe rises here; latches and byte stay for the hold cycle
          next_pins.we_n = 1'b1;
          next_ph = 2'h1;
        end
        else if (state == S_CMD1)
        begin
          next_state = S_ADDR;
          next_pins.cle = 1'b0;
          next_pins.ale = 1'b1;
          next_dbus = addr_byte(req, 2'h0);
          next_pins.we_n = 1'b0;
          next_ph = 2'h0;
        end
        else if ((state == S_ADDR) && !alast)
        begin
          next_aidx = 2'(aidx + 2'h1);
          next_dbus = addr_byte(req, 2'(aidx + 2'h1));
          next_pins.we_n = 1'b0;
          next_ph = 2'h0;
        end
        else if (load_w)
        begin
          // stall with the strobe high until a data byte is offered
          if (WDATA_VALID)
          begin
            next_state = S_WDATA;
            next_pins.ale = 1'b0;
            next_dbus = WDATA;
            next_cnt = (state == S_ADDR) ? 10'h000 : 10'(cnt + 10'h001);
            next_pins.we_n = 1'b0;
            next_ph = 2'h0;
          end
        end
        else if ((state == S_ADDR) && (req.op == nfhc_pkg::NFHC_OP_READ))
        begin
          next_state = S_WAIT;
          next_pins.ale = 1'b0;
          next_oe = 1'b0;
          next_cnt = 10'h000;
        end
        else if (state != S_CMD2)
        begin
          // execute command after the last address or data byte
          next_state = S_CMD2;
          next_pins.ale = 1'b0;
          next_pins.cle = 1'b1;
          next_dbus = (req.op == nfhc_pkg::NFHC_OP_ERASE) ? nfhc_pkg::CMD_ERASE_GO : nfhc_pkg::CMD_PROG_GO;
          next_pins.we_n = 1'b0;
          next_ph = 2'h0;
        end
        else
        begin
          next_state = S_WAIT;
          next_pins.cle = 1'b0;
          next_oe = 1'b0;
          next_cnt = 10'h000;
        end
      end
      S_WAIT:
      begin
        if (cnt != 10'h3FF)
        begin
          next_cnt = 10'(cnt + 10'h001);
        end
        if ((req.op == nfhc_pkg::NFHC_OP_READ) && (cnt == 10'(nfhc_pkg::READ_BUSY_CYC + nfhc_pkg::WB_WAIT_CYC + 2)))
        begin
          next_late = 1'b1;
        end
        // skip the busy onset window plus synchroniser delay, then wait for ready
        if ((cnt > 10'(nfhc_pkg::WB_WAIT_CYC + 1)) && rb_s2)
        begin
          next_cnt = 10'h000;
          if (req.op == nfhc_pkg::NFHC_OP_READ)
          begin
            next_state = S_RDATA;
            next_pins.rd_n = 1'b0;
            next_ph = 2'h0;
          end
          else
          begin
            next_state = S_DONE;
          end
        end
      end
      S_RDATA:
      begin
        next_ph = 2'(ph + 2'h1);
        if (ph == nfhc_pkg::RD_LOW_LAST)
        begin
          next_pins.rd_n = 1'b1;
        end
        if (ph == nfhc_pkg::RD_SAMPLE)
        begin
          next_rdata = io_s2;
          next_rvalid = 1'b1;
          next_cnt = 10'(cnt + 10'h001);
          if (cnt == rd_last)
          begin
            next_state = S_DONE;
          end
          else
          begin
            next_pins.rd_n = 1'b0;
          end
        end
      end
      S_DONE:
      begin
        next_done = 1'b1;
        next_pins.ce_n = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state <= S_IDLE;
      req <= '0;
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, rd_n: 1'b1, wp_n: 1'b0};
      ph <= 2'h0;
      aidx <= 2'h0;
      cnt <= 10'h000;
      dbus <= 8'h00;
      oe <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      done <= 1'b0;
      late <= 1'b0;
    end
    else
    begin
      state <= next_state;
      req <= next_req;
      pins <= next_pins;
      ph <= next_ph;
      aidx <= next_aidx;
      cnt <= next_cnt;
      dbus <= next_dbus;
      oe <= next_oe;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      done <= next_done;
      late <= next_late;
    end
  end

  // outputs
  assign PINS = pins;
  assign SHARED_IO_BUS_OUT = dbus;
  assign SHARED_IO_BUS_OE = oe;
  assign RDATA = rdata;
  assign RDATA_VALID = rvalid;
  assign DONE = done;
  assign READ_LATE = late;

  // =========================================================
  // checks
  logic [1:0] alat;
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      alat <= 2'h0;
    else if ($rose(pins.we_n) && pins.cle)
      alat <= 2'h0;
    else if ($rose(pins.we_n) && pins.ale)
      alat <= 2'(alat + 2'h1);
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence s_wr_low(sig);
    sig && !pins.we_n && oe;
  endsequence
  sequence s_wr_rise(sig);
    sig && pins.we_n && oe && $stable(dbus);
  endsequence

  a_no_dual_latch: assert property (!(pins.cle && pins.ale)) else $error("both latch strobes high");
  a_bus_drive: assert property (!pins.we_n |-> oe && pins.rd_n) else $error("bus not driven on write");
  a_cmd_latch: assert property (s_wr_low(pins.cle) |=> s_wr_rise(pins.cle)) else $error("command byte not held");
  a_addr_latch: assert property (s_wr_low(pins.ale) |=> s_wr_rise(pins.ale)) else $error("address byte not held");
  a_read_cycle: assert property ($fell(pins.rd_n) |-> !pins.rd_n && !oe
    ##1 !pins.rd_n ##1 !pins.rd_n ##1 pins.rd_n) else $error("read strobe too short");
  a_wait_ready: assert property (state == S_IDLE && next_state == S_CMD1 |-> rb_s2)
    else $error("started without ready");
  a_read_ready: assert property ($fell(pins.rd_n) && $past(state) == S_WAIT |-> $past(rb_s2))
    else $error("read began without ready");
  a_prog_addr: assert property (s_wr_low(pins.cle && dbus == nfhc_pkg::CMD_PROG_GO)
    |-> alat == nfhc_pkg::ADDR_CYC_PAGE) else $error("program address count wrong");
  a_erase_addr: assert property (s_wr_low(pins.cle && dbus == nfhc_pkg::CMD_ERASE_GO)
    |-> alat == nfhc_pkg::ADDR_CYC_ERASE) else $error("erase address count wrong");
endmodule

// ===== test/nfhc_flash_model.sv
// Purpose: behavioural flash device behind the host controller
// Assumes: shortened busy times; array byte is col ^ row ^ A5
// Notes: the bench shows the inverse of the last byte when the bus is released
`timescale 1ns/1ps
module nfhc_flash_model
#(
  parameter int RD_NS = 3000,
  parameter int PG_NS = 5000,
  parameter int ER_NS = 8000
)
(
  // controller pins
  input wire nfhc_pkg::nfhc_pins_type pins,
  input wire logic [7:0] bus_in,
  // device drive
  output logic [7:0] dev_out,
  output logic dev_oe,
  output logic rb_low,
  // observed state
  output logic [15:0] row_seen,
  output logic [8:0] col_seen,
  output logic [15:0] n_data,
  output logic [15:0] sum,
  output logic [7:0] n_prog,
  output logic [7:0] n_erase,
  output logic [7:0] n_clash,
  output int min_gap
);
  logic [7:0] cmd;
  logic [7:0] a [3];
  int n_addr;
  logic [8:0] ptr;
  time last_fall;
  // busy span, held whatever chip select does
  task automatic work(input int ns);
    rb_low = 1'b1;
    #(ns);
    rb_low = 1'b0;
  endtask
  // =========================================================
  // power-up state
  initial
  begin
    {dev_out, rb_low, row_seen, col_seen, n_data, sum} = '0;
    {n_prog, n_erase, n_clash, cmd, ptr} = '0;
    n_addr = 0;
    min_gap = 1000000;
    last_fall = 0;
  end
  // drive only while selected and read strobe low
  assign dev_oe = !pins.ce_n && !pins.rd_n;
  // =========================================================
  // latch on the write strobe rising edge
  always @(posedge pins.we_n)
  begin
    if (!pins.ce_n && !rb_low)
    begin
      if (pins.cle && pins.ale) n_clash = n_clash + 8'h01;
      if (pins.cle && bus_in == 8'h10 && cmd == 8'h80 && pins.wp_n)
      begin
        n_prog = n_prog + 8'h01;
        work(PG_NS);
      end
      else if (pins.cle && bus_in == 8'hD0 && cmd == 8'h60 && pins.wp_n)
      begin
        n_erase = n_erase + 8'h01;
        work(ER_NS);
      end
      else if (pins.cle)
      begin
        cmd = bus_in;
        n_addr = 0;
        if (bus_in == 8'h80) {n_data, sum} = '0;
      end
      else if (pins.ale && n_addr < ((cmd == 8'h60) ? 2 : 3))
      begin
        a[n_addr] = bus_in;
        n_addr++;
        row_seen = (cmd == 8'h60) ? {a[1], a[0]} : {a[2], a[1]};
        if (n_addr == 3 && cmd[7:1] == 7'h00)
        begin
          col_seen = {cmd[0], a[0]};
          ptr = col_seen;
          work(RD_NS);
        end
      end
      else if (!pins.ale && cmd == 8'h80)
      begin
        n_data = n_data + 16'h0001;
        sum = sum + {8'h00, bus_in};
      end
    end
  end
  // serial output, column advances on each read strobe fall
  always @(negedge pins.rd_n)
  begin
    if (!pins.ce_n && !rb_low)
    begin
      if (int'($time - last_fall) < min_gap) min_gap = int'($time - last_fall);
      last_fall = $time;
      dev_out = col_seen[7:0] ^ col_seen[7:0] ^ ptr[7:0] ^ row_seen[7:0] ^ 8'hA5;
      ptr = ptr + 9'h001;
    end
  end
endmodule

// ===== test/nfhc_ctrl_tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: behavioural device model, pull-up on ready/busy
// Notes: outputs sampled on the falling clock edge
`timescale 1ns/1ps
module nfhc_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst, req_valid, req_ready, allow_write, wdata_valid, wdata_ready;
  logic rdata_valid, done, read_late, bus_oe, dev_oe, rb_low, take_next;
  logic [7:0] wdata, rdata, bus_out, dev_out, n_prog, n_erase, n_clash;
  logic [15:0] row_seen, n_data, sum;
  logic [8:0] col_seen;
  int min_gap, n_fail = 0, tests_run = 0;
  nfhc_pkg::nfhc_req_type req;
  nfhc_pkg::nfhc_pins_type pins;
  logic [7:0] got_q [$];
  // =========================================================
  // clock, wire levels and write data feed
  always #50 clk_sys = ~clk_sys;
  wire logic [7:0] bus_in = bus_oe ? bus_out : (dev_oe ? dev_out : ~dev_out);
  wire logic rb_in = ~rb_low;
  always @(negedge clk_sys) take_next <= wdata_valid && wdata_ready;
  always @(posedge clk_sys) if (take_next) wdata <= wdata + 8'h01;
  always @(negedge clk_sys) if (bus_oe === 1'b1 && dev_oe === 1'b1) chk(8'h01, 8'h00);
  nfhc_ctrl DUT (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .ALLOW_WRITE(allow_write), .WDATA(wdata), .WDATA_VALID(wdata_valid),
    .WDATA_READY(wdata_ready), .RDATA(rdata), .RDATA_VALID(rdata_valid), .DONE(done),
    .READ_LATE(read_late), .PINS(pins), .SHARED_IO_BUS_IN(bus_in), .SHARED_IO_BUS_OUT(bus_out),
    .SHARED_IO_BUS_OE(bus_oe), .READY_BUSY_IN(rb_in));
  nfhc_flash_model flash (.pins(pins), .bus_in(bus_in), .dev_out(dev_out), .dev_oe(dev_oe),
    .rb_low(rb_low), .row_seen(row_seen), .col_seen(col_seen), .n_data(n_data), .sum(sum),
    .n_prog(n_prog), .n_erase(n_erase), .n_clash(n_clash), .min_gap(min_gap));
  // =========================================================
  // compare, verdict and request helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request, then wait for completion gathering read bytes
  task automatic run(input nfhc_pkg::nfhc_op_type op, input logic [8:0] col, input logic [15:0] row);
    int k;
    bit seen;
    got_q.delete();
    seen = 1'b0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{op: op, col: col, row: row};
    // hold the request until ready is seen before a sampling edge
    @(negedge clk_sys);
    for (k = 0; k < 1000 && req_ready !== 1'b1; k++) @(negedge clk_sys);
    chk(req_ready, 1'b1);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (k = 0; k < 30000 && done !== 1'b1; k++)
    begin
      @(negedge clk_sys);
      if (rdata_valid === 1'b1) got_q.push_back(rdata);
      if (rb_low && !seen) chk(req_ready, 1'b0);
      seen |= rb_low;
    end
    chk(done, 1'b1);
  endtask
  // page read from a column to the end of the page
  task automatic t_read(input logic [8:0] col);
    logic [15:0] r;
    r = 16'h1234 + {7'h00, col};
    run(nfhc_pkg::NFHC_OP_READ, col, r);
    chk(got_q.size(), 528 - col);
    foreach (got_q[i]) chk(got_q[i], 8'(col[7:0] + 8'(i)) ^ r[7:0] ^ 8'hA5);
    chk({col_seen, row_seen}, {col, r});
    chk(read_late, 1'b0);
    chk(min_gap >= 50, 1'b1);
    $display("read test col %0h finished", col);
  endtask
  // block erase
  task automatic t_erase(input logic [15:0] r);
    logic [7:0] e0;
    e0 = n_erase;
    run(nfhc_pkg::NFHC_OP_ERASE, 9'h000, r);
    chk(n_erase, e0 + 8'h01);
    chk(row_seen, r);
    $display("erase test finished");
  endtask
  // page program, write protect set by allow
  task automatic t_prog(input logic allow, input logic [15:0] r);
    logic [7:0] p0;
    logic [15:0] s;
    p0 = n_prog;
    s = 16'h0000;
    for (int i = 0; i < 528; i++) s = s + {8'h00, 8'(i)};
    @(posedge clk_sys);
    allow_write <= allow;
    wdata <= 8'h00;
    wdata_valid <= 1'b1;
    run(nfhc_pkg::NFHC_OP_PROG, 9'h000, r);
    @(posedge clk_sys);
    wdata_valid <= 1'b0;
    chk({n_data, sum}, {16'h0210, s});
    chk(n_prog, p0 + {7'h00, allow});
    chk(row_seen, r);
    $display("program test allow %0d finished", allow);
  endtask
  // =========================================================
  // main sequence and watchdog
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    allow_write = 1'b0;
    wdata = 8'h00;
    wdata_valid = 1'b0;
    take_next = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({req_ready, pins, bus_oe}, {1'b1, 6'h26, 1'b0});
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_read(9'h20F);
    t_read(9'h1F0);
    t_read(9'h0FE);
    t_prog(1'b1, 16'h4321);
    t_erase(16'h0ABC);
    t_prog(1'b0, 16'h4322);
    chk(n_clash, 8'h00);
    close_out();
  end
  initial
  begin
    #3000000;
    n_fail++;
    close_out();
  end
endmodule
